//--- rtl/acr_map.svh
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// Register offsets
`define ACR_OFF_CHAN      10'h001
`define ACR_OFF_RATE      10'h002
`define ACR_OFF_RBEDGE    10'h004
`define ACR_OFF_RANDPOL   10'h007
`define ACR_OFF_CALDLY    10'h01E
`define ACR_OFF_DLL       10'h052
`define ACR_OFF_SRC       10'h053
`define ACR_OFF_REFLO     10'h054
`define ACR_OFF_OUTDIV    10'h055

// Register array indices
`define ACR_IDX_CHAN      4'h0
`define ACR_IDX_RATE      4'h1
`define ACR_IDX_RBEDGE    4'h2
`define ACR_IDX_RANDPOL   4'h3
`define ACR_IDX_CALDLY    4'h4
`define ACR_IDX_DLL       4'h5
`define ACR_IDX_SRC       4'h6
`define ACR_IDX_REFLO     4'h7
`define ACR_IDX_OUTDIV    4'h8
`define ACR_IDX_NONE      4'hF
`define ACR_NUM_REGS      9

// Reset values
`define ACR_RST_CHAN      8'h0F
`define ACR_RST_RATE      8'h00
`define ACR_RST_RBEDGE    8'h9F
`define ACR_RST_RANDPOL   8'h62
`define ACR_RST_CALDLY    8'h80
`define ACR_RST_DLL       8'h0A
`define ACR_RST_SRC       8'h45
`define ACR_RST_REFLO     8'h00
`define ACR_RST_OUTDIV    8'h48

// Field positions
`define ACR_B_INDEP       7
`define ACR_F_NCH         5:3
`define ACR_F_WRATE       7:4
`define ACR_F_CRATE       3:0
`define ACR_B_RBEDGE      7
`define ACR_B_WCKINV      7
`define ACR_B_CALEN       6
`define ACR_B_RANDOM      0
`define ACR_B_DUTY        7
`define ACR_F_PHASE       6:4
`define ACR_B_LOOPCLK     3
`define ACR_B_DLLEN       2
`define ACR_B_CLKBUF      1
`define ACR_B_DLLRUN      0
`define ACR_B_PLLSRC      4
`define ACR_F_SYNDIV      7:4
`define ACR_F_REFHI       1:0

// Serial frame layout
`define ACR_HDR_BITS      5'd16
`define ACR_FRAME_BITS    5'd24
`define ACR_HDR_READ      15
`define ACR_HDR_ADDR      9:0

// Pin synchroniser reset levels: {csN, sclk, sdi}
`define ACR_PIN_RST       3'h4

`endif

//--- rtl/acr_pkg.sv
package acr_pkg;
  typedef logic [7:0]  acr_byte_t;
  typedef logic [15:0] acr_word_t;
  typedef logic [9:0]  acr_addr_t;
  typedef logic [3:0]  acr_code_t;

  typedef enum logic [1:0] {
    ACR_IDLE   = 2'b00,
    ACR_HEADER = 2'b01,
    ACR_DATA   = 2'b10
  } acr_spi_state_t;
endpackage

//--- rtl/acr_regs.sv
`timescale 1ns/1ns
`include "acr_map.svh"

module acr_regs (
  // Clocking
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  // Serial configuration port
  input  wire logic                spiSclk,
  input  wire logic                spiCsN,
  input  wire logic                spiSdi,
  output logic                     sdoOut,
  output logic                     sdoOe,
  // Converter word path
  input  wire acr_pkg::acr_word_t  adcData,
  input  wire logic                adcStrobe,
  output acr_pkg::acr_word_t       dataOut,
  output logic                     dataValid,
  output logic                     wordClockOut,
  output logic                     dataClockOut,
  // Settings held in neighbouring registers
  input  wire logic                phaseDelayEnable,
  input  wire logic                decimationActive,
  input  wire logic                refDividerEnable,
  // Clock and analog controls
  output logic [3:0]               channelCount,
  output logic                     dutyCorrectOn,
  output logic [2:0]               outputClockPhase,
  output logic                     loopClockOutputEnable,
  output logic                     dllEnable,
  output logic                     clkBufferEnable,
  output logic                     dllActive,
  output logic                     timingSourcePll,
  output logic [9:0]               refDivRatio,
  output logic [3:0]               synthDivRatio,
  output logic [7:0]               calStartDelay
);
  import acr_pkg::*;

  function automatic logic [3:0] regIndex(input acr_addr_t a);
    case (a)
      `ACR_OFF_CHAN:    regIndex = `ACR_IDX_CHAN;
      `ACR_OFF_RATE:    regIndex = `ACR_IDX_RATE;
      `ACR_OFF_RBEDGE:  regIndex = `ACR_IDX_RBEDGE;
      `ACR_OFF_RANDPOL: regIndex = `ACR_IDX_RANDPOL;
      `ACR_OFF_CALDLY:  regIndex = `ACR_IDX_CALDLY;
      `ACR_OFF_DLL:     regIndex = `ACR_IDX_DLL;
      `ACR_OFF_SRC:     regIndex = `ACR_IDX_SRC;
      `ACR_OFF_REFLO:   regIndex = `ACR_IDX_REFLO;
      `ACR_OFF_OUTDIV:  regIndex = `ACR_IDX_OUTDIV;
      default:          regIndex = `ACR_IDX_NONE;
    endcase
  endfunction

  function automatic acr_byte_t resetValue(input int i);
    case (i)
      0:       resetValue = `ACR_RST_CHAN;
      1:       resetValue = `ACR_RST_RATE;
      2:       resetValue = `ACR_RST_RBEDGE;
      3:       resetValue = `ACR_RST_RANDPOL;
      4:       resetValue = `ACR_RST_CALDLY;
      5:       resetValue = `ACR_RST_DLL;
      6:       resetValue = `ACR_RST_SRC;
      7:       resetValue = `ACR_RST_REFLO;
      default: resetValue = `ACR_RST_OUTDIV;
    endcase
  endfunction

  // Divisor minus one for a rate code; codes outside 1..9 give full speed
  function automatic logic [9:0] rateDivM1(input acr_code_t c);
    if (c >= 4'h1 && c <= 4'h9) begin
      rateDivM1 = 10'((10'h001 << c) - 10'h001);
    end else begin
      rateDivM1 = 10'h000;
    end
  endfunction

  // Pin synchronisers: {csN, sclk, sdi}
  logic [2:0] pinS1;
  logic [2:0] pinS2;
  logic [2:0] pinS3;
  logic [2:0] pinF_reg;
  logic       sclkPrev_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinS1        <= `ACR_PIN_RST;
      pinS2        <= `ACR_PIN_RST;
      pinS3        <= `ACR_PIN_RST;
      pinF_reg     <= `ACR_PIN_RST;
      sclkPrev_reg <= 1'b0;
    end else if (ce) begin
      pinS1        <= {spiCsN, spiSclk, spiSdi};
      pinS2        <= pinS1;
      pinS3        <= pinS2;
      for (int i = 0; i < 3; i++) begin
        if (pinS2[i] == pinS3[i]) begin
          pinF_reg[i] <= pinS3[i];
        end
      end
      sclkPrev_reg <= pinF_reg[1];
    end
  end

  logic csN;
  logic sdiBit;
  logic sclkRise;
  logic sclkFall;
  assign csN      = pinF_reg[2];
  assign sdiBit   = pinF_reg[0];
  assign sclkRise = pinF_reg[1] & ~sclkPrev_reg;
  assign sclkFall = ~pinF_reg[1] & sclkPrev_reg;

  // Register storage
  acr_byte_t cfgReg [0:`ACR_NUM_REGS-1];

  // Serial frame engine
  acr_spi_state_t spiState_reg;
  logic [4:0] bitCnt_reg;
  logic [15:0] hdr_reg;
  acr_byte_t  wrShift_reg;
  acr_byte_t  rdShift_reg;
  logic       isRead_reg;
  logic       wrStrobe;
  logic [3:0] hdrIdx;
  logic [15:0] hdrNext;
  logic       launchEdge;

  assign hdrNext    = {hdr_reg[14:0], sdiBit};
  assign hdrIdx     = regIndex(hdrNext[`ACR_HDR_ADDR]);
  assign wrStrobe   = (spiState_reg == ACR_DATA) && sclkRise && !isRead_reg
                      && (bitCnt_reg == 5'(`ACR_FRAME_BITS - 5'd1));
  assign launchEdge = cfgReg[`ACR_IDX_RBEDGE][`ACR_B_RBEDGE] ? sclkFall : sclkRise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spiState_reg <= ACR_IDLE;
      bitCnt_reg   <= 5'h00;
      hdr_reg      <= 16'h0000;
      wrShift_reg  <= 8'h00;
      isRead_reg   <= 1'b0;
    end else if (ce) begin
      if (csN) begin
        spiState_reg <= ACR_IDLE;
        bitCnt_reg   <= 5'h00;
        isRead_reg   <= 1'b0;
      end else begin
        case (spiState_reg)
          ACR_IDLE: begin
            spiState_reg <= ACR_HEADER;
          end
          ACR_HEADER: begin
            if (sclkRise) begin
              hdr_reg    <= hdrNext;
              bitCnt_reg <= bitCnt_reg + 5'd1;
              if (bitCnt_reg == 5'(`ACR_HDR_BITS - 5'd1)) begin
                spiState_reg <= ACR_DATA;
                isRead_reg   <= hdrNext[`ACR_HDR_READ];
              end
            end
          end
          ACR_DATA: begin
            if (sclkRise && bitCnt_reg != `ACR_FRAME_BITS) begin
              wrShift_reg <= {wrShift_reg[6:0], sdiBit};
              bitCnt_reg  <= bitCnt_reg + 5'd1;
            end
          end
          default: begin
            spiState_reg <= ACR_IDLE;
          end
        endcase
      end
    end
  end

  // Register writes; every bit stored as written, factory positions too
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `ACR_NUM_REGS; i++) begin
        cfgReg[i] <= resetValue(i);
      end
    end else if (ce && wrStrobe) begin
      if (regIndex(hdr_reg[`ACR_HDR_ADDR]) != `ACR_IDX_NONE) begin
        cfgReg[regIndex(hdr_reg[`ACR_HDR_ADDR])] <= {wrShift_reg[6:0], sdiBit};
      end
    end
  end

  // Readback; unmapped addresses return zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdShift_reg <= 8'h00;
      sdoOut      <= 1'b0;
      sdoOe       <= 1'b0;
    end else if (ce) begin
      if (csN) begin
        sdoOe <= 1'b0;
      end else if (spiState_reg == ACR_HEADER && sclkRise
                   && bitCnt_reg == 5'(`ACR_HDR_BITS - 5'd1)) begin
        rdShift_reg <= (hdrIdx == `ACR_IDX_NONE) ? 8'h00 : cfgReg[hdrIdx];
        sdoOe       <= hdrNext[`ACR_HDR_READ];
      end else if (spiState_reg == ACR_DATA && isRead_reg && launchEdge) begin
        sdoOut      <= rdShift_reg[7];
        rdShift_reg <= {rdShift_reg[6:0], 1'b0};
      end
    end
  end

  // Decoded settings
  acr_byte_t rChan;
  acr_byte_t rRate;
  acr_byte_t rRand;
  acr_byte_t rDll;
  assign rChan = cfgReg[`ACR_IDX_CHAN];
  assign rRate = cfgReg[`ACR_IDX_RATE];
  assign rRand = cfgReg[`ACR_IDX_RANDPOL];
  assign rDll  = cfgReg[`ACR_IDX_DLL];
  logic [9:0] refFull;
  assign refFull = {cfgReg[`ACR_IDX_OUTDIV][`ACR_F_REFHI], cfgReg[`ACR_IDX_REFLO]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channelCount          <= 4'h1;
      dutyCorrectOn         <= 1'b0;
      outputClockPhase      <= 3'h0;
      loopClockOutputEnable <= 1'b1;
      dllEnable             <= 1'b0;
      clkBufferEnable       <= 1'b1;
      dllActive             <= 1'b0;
      timingSourcePll       <= 1'b0;
      refDivRatio           <= 10'h001;
      synthDivRatio         <= 4'h4;
      calStartDelay         <= 8'h00;
    end else if (ce) begin
      channelCount <= (rChan[`ACR_F_NCH] == 3'h0) ? 4'h8 : {1'b0, rChan[`ACR_F_NCH]};
      dutyCorrectOn <= rDll[`ACR_B_DUTY];
      outputClockPhase <= (phaseDelayEnable && !decimationActive)
                          ? rDll[`ACR_F_PHASE] : 3'h0;
      loopClockOutputEnable <= rDll[`ACR_B_LOOPCLK];
      dllEnable       <= rDll[`ACR_B_DLLEN];
      clkBufferEnable <= rDll[`ACR_B_CLKBUF];
      dllActive       <= rDll[`ACR_B_DLLRUN];
      timingSourcePll <= cfgReg[`ACR_IDX_SRC][`ACR_B_PLLSRC];
      refDivRatio <= (refDividerEnable && refFull > 10'h002) ? refFull : 10'h001;
      synthDivRatio <= (cfgReg[`ACR_IDX_OUTDIV][`ACR_F_SYNDIV] == 4'h0)
                       ? 4'h1 : cfgReg[`ACR_IDX_OUTDIV][`ACR_F_SYNDIV];
      calStartDelay <= rRand[`ACR_B_CALEN] ? cfgReg[`ACR_IDX_CALDLY] : 8'h00;
    end
  end

  // Output word path; each rate code is latched when its own divider count wraps
  acr_code_t  wordCode_reg;
  acr_code_t  clkCode_reg;
  logic [9:0] wordCnt_reg;
  logic [9:0] clkCnt_reg;
  logic       indep;
  logic       outputLive;
  logic       emitWord;
  logic       clkTick;
  logic       clkOff;
  logic       zeroData;

  assign indep      = rChan[`ACR_B_INDEP];
  assign outputLive = clkBufferEnable && !(dllEnable && !loopClockOutputEnable);
  assign emitWord   = outputLive && adcStrobe && (wordCnt_reg == rateDivM1(wordCode_reg));
  assign clkTick    = outputLive && adcStrobe && (clkCnt_reg == rateDivM1(clkCode_reg));
  assign clkOff     = indep && (clkCode_reg == 4'h0 || (clkCode_reg >= 4'hA && clkCode_reg <= 4'hE));
  assign zeroData   = (wordCode_reg >= 4'hD);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wordCode_reg <= 4'h0;
      wordCnt_reg  <= 10'h000;
    end else if (ce && outputLive && adcStrobe) begin
      if (emitWord) begin
        wordCnt_reg  <= 10'h000;
        wordCode_reg <= rRate[`ACR_F_WRATE];
      end else begin
        wordCnt_reg  <= wordCnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clkCode_reg <= 4'h0;
      clkCnt_reg  <= 10'h000;
    end else if (ce && outputLive && adcStrobe) begin
      if (clkTick) begin
        clkCnt_reg  <= 10'h000;
        clkCode_reg <= rRate[`ACR_F_CRATE];
      end else begin
        clkCnt_reg  <= clkCnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataOut      <= 16'h0000;
      dataValid    <= 1'b0;
      wordClockOut <= 1'b0;
    end else if (ce) begin
      dataValid    <= emitWord;
      wordClockOut <= emitWord ^ rRand[`ACR_B_WCKINV];
      if (!outputLive || (emitWord && zeroData)) begin
        dataOut <= 16'h0000;
      end else if (emitWord && rRand[`ACR_B_RANDOM]) begin
        dataOut <= adcData ^ {{15{adcData[0]}}, 1'b0};
      end else if (emitWord) begin
        dataOut <= adcData;
      end
    end
  end

  // Data clock follows the word rate unless the independent divider is on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataClockOut <= 1'b0;
    end else if (ce) begin
      if (!outputLive || clkOff) begin
        dataClockOut <= 1'b0;
      end else if (indep ? clkTick : emitWord) begin
        dataClockOut <= ~dataClockOut;
      end
    end
  end

  a_zero_words: assert property (@(posedge clk) disable iff (!nrst)
    (ce && emitWord && zeroData) |=> (dataOut == 16'h0000))
    else $error("data not zero for zeroing rate code");
  a_clock_off: assert property (@(posedge clk) disable iff (!nrst)
    (ce && clkOff) |=> !dataClockOut)
    else $error("data clock running while off");
  a_word_clock: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !emitWord && !rRand[`ACR_B_WCKINV]) |=> !wordClockOut)
    else $error("word clock high without word");
  a_cal_gate: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !rRand[`ACR_B_CALEN]) |=> (calStartDelay == 8'h00))
    else $error("calibration delay used while disabled");
  a_phase_gate: assert property (@(posedge clk) disable iff (!nrst)
    (ce && decimationActive) |=> (outputClockPhase == 3'h0))
    else $error("phase applied during decimation");
  a_clkbuf_off: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !clkBufferEnable) |=> (!dataValid && dataOut == 16'h0000))
    else $error("output produced with clock buffer off");
  a_dll_reset: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !rDll[`ACR_B_DLLRUN]) |=> !dllActive)
    else $error("loop released while reset bit low");
  a_ref_bypass: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !refDividerEnable) |=> (refDivRatio == 10'h001))
    else $error("reference divider active while bypassed");
  a_ref_two: assert property (@(posedge clk) disable iff (!nrst)
    (ce && refFull == 10'h002) |=> (refDivRatio == 10'h001))
    else $error("reference divide by two applied");
  a_syn_div: assert property (@(posedge clk) disable iff (!nrst)
    ce |=> (synthDivRatio != 4'h0))
    else $error("output divider ratio zero");
  a_chan_eight: assert property (@(posedge clk) disable iff (!nrst)
    (ce && rChan[`ACR_F_NCH] == 3'h0) |=> (channelCount == 4'h8))
    else $error("code zero not eight channels");
  a_write_back: assert property (@(posedge clk) disable iff (!nrst)
    (ce && wrStrobe && hdr_reg[`ACR_HDR_ADDR] == `ACR_OFF_CALDLY)
    |=> (cfgReg[`ACR_IDX_CALDLY] == {7'($past(wrShift_reg)), $past(sdiBit)}))
    else $error("written value not stored");

endmodule

//--- tb/acr_host.sv
`timescale 1ns/1ns

module acr_host #(
  parameter int HALF = 8
) (
  // Clocking
  input  wire logic clk,
  // Serial pins
  output logic      spiSclk,
  output logic      spiCsN,
  output logic      spiSdi,
  input  wire logic sdoOut,
  input  wire logic sdoOe
);
  initial begin
    spiSclk = 1'b0;
    spiCsN  = 1'b1;
    spiSdi  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One frame, MSB first; fewer than 24 bits aborts it
  task automatic xfer(input logic rd, input logic [9:0] addr, input logic [7:0] wdat,
                      input logic fallLaunch, input int nBits, output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, 5'h00, addr, wdat};
    rdat = 8'h00;
    @(posedge clk);
    spiCsN <= 1'b0;
    for (int i = 0; i < nBits; i++) begin
      spiSdi <= frame[23-i];
      tick(HALF);
      // Sample just before the next rising edge, once read data is being launched
      if (i >= (fallLaunch ? 16 : 17)) rdat = {rdat[6:0], sdoOe ? sdoOut : 1'bx};
      spiSclk <= 1'b1;
      tick(HALF);
      spiSclk <= 1'b0;
    end
    tick(HALF);
    if (!fallLaunch && nBits == 24) rdat = {rdat[6:0], sdoOe ? sdoOut : 1'bx};
    spiCsN <= 1'b1;
    // Released data line shows no stale level
    spiSdi <= ~spiSdi;
    tick(2*HALF);
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns

module tb_top;
  import acr_pkg::*;
  localparam logic [9:0] OFFS [9] = '{10'h001, 10'h002, 10'h004, 10'h007, 10'h01e,
                                      10'h052, 10'h053, 10'h054, 10'h055};
  localparam logic [7:0] RSTS [9] = '{8'h0f, 8'h00, 8'h9f, 8'h62, 8'h80,
                                      8'h0a, 8'h45, 8'h00, 8'h48};
  logic        clk, nrst, ce, spiSclk, spiCsN, spiSdi, sdoOut, sdoOe, fallLaunch, lastClk;
  acr_word_t   adcData, dataOut;
  logic        adcStrobe, dataValid, wordClockOut, dataClockOut;
  logic        phaseDelayEnable, decimationActive, refDividerEnable;
  logic [3:0]  channelCount, synthDivRatio;
  logic [2:0]  outputClockPhase;
  logic [9:0]  refDivRatio;
  logic [7:0]  calStartDelay;
  logic        dutyCorrectOn, loopClockOutputEnable, dllEnable, clkBufferEnable;
  logic        dllActive, timingSourcePll;
  int          bad_count, tests_run, cycles, nValid, nToggle;

  acr_regs dut (.clk(clk), .nrst(nrst), .ce(ce), .spiSclk(spiSclk), .spiCsN(spiCsN),
    .spiSdi(spiSdi), .sdoOut(sdoOut), .sdoOe(sdoOe), .adcData(adcData),
    .adcStrobe(adcStrobe), .dataOut(dataOut), .dataValid(dataValid),
    .wordClockOut(wordClockOut), .dataClockOut(dataClockOut),
    .phaseDelayEnable(phaseDelayEnable), .decimationActive(decimationActive),
    .refDividerEnable(refDividerEnable), .channelCount(channelCount),
    .dutyCorrectOn(dutyCorrectOn), .outputClockPhase(outputClockPhase),
    .loopClockOutputEnable(loopClockOutputEnable), .dllEnable(dllEnable),
    .clkBufferEnable(clkBufferEnable), .dllActive(dllActive),
    .timingSourcePll(timingSourcePll), .refDivRatio(refDivRatio),
    .synthDivRatio(synthDivRatio), .calStartDelay(calStartDelay));

  acr_host host (.clk(clk), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdi(spiSdi),
    .sdoOut(sdoOut), .sdoOe(sdoOe));

  always #5 clk = ~clk;

  // Word and clock-edge counters, plus the hang limit
  always @(posedge clk) begin
    cycles++;
    if (dataValid === 1'b1) nValid++;
    if (dataClockOut !== lastClk) nToggle++;
    lastClk = dataClockOut;
    if (cycles == 80000) begin
      bad_count++;
      results();
    end
  end

  task automatic results;
    $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer(1'b0, a, d, fallLaunch, 24, r);
  endtask

  task automatic rdc(input string what, input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] r;
    host.xfer(1'b1, a, 8'h00, fallLaunch, 24, r);
    chk(what, {8'h00, exp}, {8'h00, r});
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      adcStrobe <= 1'b1;
    end
    @(posedge clk);
    adcStrobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Words and clock edges seen over 64 strobes, after a flush
  task automatic rate(input int expV, input int expT);
    int v, t;
    pulses(32);
    v = nValid;
    t = nToggle;
    pulses(64);
    chk("valid words", 16'(expV), 16'(nValid - v));
    chk("clock edges", 16'(expT), 16'(nToggle - t));
  endtask

  task automatic t_reset;
    chk("channels", 16'h0001, 16'(channelCount));
    chk("synth div", 16'h0004, 16'(synthDivRatio));
    chk("ref div", 16'h0001, 16'(refDivRatio));
    chk("cal delay", 16'h0080, 16'(calStartDelay));
    chk("flags", 16'h0030, 16'({dutyCorrectOn, loopClockOutputEnable, clkBufferEnable,
        dllEnable, dllActive, timingSourcePll, wordClockOut}));
    for (int i = 0; i < 9; i++) rdc("reset value", OFFS[i], RSTS[i]);
    rdc("unmapped", 10'h003, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_chan;
    for (int c = 0; c < 8; c++) begin
      wr(10'h001, {2'b00, 3'(c), 3'b111});
      chk("channels", (c == 0) ? 16'h0008 : 16'(c), 16'(channelCount));
      rdc("reg01", 10'h001, {2'b00, 3'(c), 3'b111});
    end
    wr(10'h001, 8'h0f);
    $display("test channels done");
  endtask

  task automatic t_word;
    int codes [3] = '{0, 1, 4};
    foreach (codes[k]) begin
      wr(10'h002, {4'(codes[k]), 4'h0});
      rate(64 >> codes[k], 64 >> codes[k]);
      chk("word", 16'ha5c3, dataOut);
    end
    // Codes 1010..1100 are never programmed
    for (int c = 13; c < 16; c++) begin
      wr(10'h002, {4'(c), 4'h0});
      pulses(8);
      chk("zero word", 16'h0000, dataOut);
    end
    wr(10'h002, 8'h00);
    $display("test word rate done");
  endtask

  task automatic t_clk;
    int cc [4] = '{0, 1, 15, 10};
    int ct [4] = '{0, 32, 64, 0};
    wr(10'h001, 8'h8f);
    foreach (cc[k]) begin
      wr(10'h002, {4'h0, 4'(cc[k])});
      rate(64, ct[k]);
    end
    wr(10'h001, 8'h0f);
    wr(10'h002, 8'h1f);
    rate(32, 32);
    wr(10'h002, 8'h00);
    $display("test clock rate done");
  endtask

  task automatic t_out;
    wr(10'h007, 8'h63);
    pulses(4);
    chk("randomized", 16'h5a3d, dataOut);
    wr(10'h007, 8'he2);
    chk("word clock", 16'h0001, 16'(wordClockOut));
    wr(10'h007, 8'h62);
    chk("word clock", 16'h0000, 16'(wordClockOut));
    wr(10'h01e, 8'hff);
    chk("cal delay", 16'h00ff, 16'(calStartDelay));
    wr(10'h007, 8'h22);
    chk("cal delay", 16'h0000, 16'(calStartDelay));
    wr(10'h007, 8'h62);
    wr(10'h01e, 8'h00);
    chk("cal delay", 16'h0000, 16'(calStartDelay));
    wr(10'h01e, 8'h80);
    $display("test output mods done");
  endtask

  task automatic t_loop;
    @(posedge clk) phaseDelayEnable <= 1'b1;
    wr(10'h052, 8'hdf);
    chk("loop flags", 16'h000f, 16'({dutyCorrectOn, dllEnable, clkBufferEnable,
        dllActive}));
    chk("phase", 16'h0005, 16'(outputClockPhase));
    @(posedge clk) decimationActive <= 1'b1;
    repeat (3) @(posedge clk);
    chk("phase", 16'h0000, 16'(outputClockPhase));
    @(posedge clk) decimationActive <= 1'b0;
    phaseDelayEnable <= 1'b0;
    repeat (3) @(posedge clk);
    chk("phase", 16'h0000, 16'(outputClockPhase));
    wr(10'h052, 8'hde);
    chk("loop run", 16'h0000, 16'(dllActive));
    wr(10'h052, 8'hdf);
    chk("loop run", 16'h0001, 16'(dllActive));
    wr(10'h052, 8'h06);
    chk("loop clock", 16'h0000, 16'(loopClockOutputEnable));
    pulses(4);
    chk("no output", 16'h0000, dataOut);
    wr(10'h052, 8'h0a);
    pulses(4);
    chk("word", 16'ha5c3, dataOut);
    wr(10'h052, 8'h08);
    pulses(4);
    chk("no output", 16'h0000, dataOut);
    wr(10'h052, 8'h0a);
    $display("test loop control done");
  endtask

  task automatic t_pll;
    wr(10'h053, 8'h55);
    chk("pll source", 16'h0001, 16'(timingSourcePll));
    wr(10'h053, 8'h45);
    chk("pll source", 16'h0000, 16'(timingSourcePll));
    @(posedge clk) refDividerEnable <= 1'b1;
    wr(10'h054, 8'h03);
    chk("ref div", 16'h0003, 16'(refDivRatio));
    wr(10'h054, 8'h02);
    chk("ref div", 16'h0001, 16'(refDivRatio));
    wr(10'h055, 8'hf9);
    chk("ref div", 16'h0102, 16'(refDivRatio));
    chk("synth div", 16'h000f, 16'(synthDivRatio));
    @(posedge clk) refDividerEnable <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ref div", 16'h0001, 16'(refDivRatio));
    wr(10'h055, 8'h08);
    chk("synth div", 16'h0001, 16'(synthDivRatio));
    rdc("reg55", 10'h055, 8'h08);
    wr(10'h055, 8'h48);
    wr(10'h054, 8'h00);
    $display("test pll done");
  endtask

  task automatic t_serial;
    logic [7:0] r;
    wr(10'h004, 8'h1f);
    fallLaunch = 1'b0;
    rdc("reg04", 10'h004, 8'h1f);
    rdc("reg1e", 10'h01e, 8'h80);
    wr(10'h004, 8'h9f);
    fallLaunch = 1'b1;
    rdc("reg04", 10'h004, 8'h9f);
    host.xfer(1'b0, 10'h01e, 8'h11, fallLaunch, 20, r);
    rdc("aborted", 10'h01e, 8'h80);
    wr(10'h003, 8'h5a);
    rdc("unmapped", 10'h003, 8'h00);
    $display("test serial done");
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    adcData = 16'ha5c3;
    adcStrobe = 1'b0;
    phaseDelayEnable = 1'b0;
    decimationActive = 1'b0;
    refDividerEnable = 1'b0;
    fallLaunch = 1'b1;
    lastClk = 1'b0;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    nValid = 0;
    nToggle = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_chan();
    t_word();
    t_clk();
    t_out();
    t_loop();
    t_pll();
    t_serial();
    results();
  end
endmodule
